// ---- design/vhpm_params.svh ----
`ifndef VHPM_PARAMS_SVH
`define VHPM_PARAMS_SVH
// ----------------------------------------
// Register indices behind the data port
// ----------------------------------------
`define VHPM_IDX_LOW_PAGE 8'h1D
`define VHPM_IDX_HIGH_PAGE 8'h1E
`define VHPM_IDX_EXT_ENABLE 8'h1F
`define VHPM_IDX_EXT_BASE 8'h20
`define VHPM_IDX_APERTURE 8'h21
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define VHPM_ENABLE_BIT 7
`define VHPM_PAGE_RST 7'h00
`define VHPM_BASE_RST 3'h0
`define VHPM_APERTURE_RST 8'hFF
`define VHPM_AP_USE_PAT 2'h1
`define VHPM_INDEX_RST 8'h00
// ----------------------------------------
// Legacy window placement
// ----------------------------------------
`define VHPM_LEGACY_SEG 16'h000A
`define VHPM_HIGH_WIN_BIT 15
`endif

// ---- design/vhpm_pkg.sv ----
package vhpm_pkg;
	// Page value that extends host window addresses
	typedef logic [6:0] vhpm_page_t;
	// Which page register a host cycle uses
	typedef enum logic [1:0] {
		VHPM_PICK_LOW = 2'b01,
		VHPM_PICK_HIGH = 2'b10
	} vhpm_pick_t;
	// Frame buffer and aperture address width (4 MB)
	typedef logic [21:0] vhpm_fbaddr_t;
endpackage

// ---- design/vhpm_map.sv ----
`timescale 1ns/10ps
`include "vhpm_params.svh"
module vhpm_map (
	input wire vhpm_pkg::vhpm_page_t i_page_low,
	input wire vhpm_pkg::vhpm_page_t i_page_high,
	input wire logic i_page_pick_control,
	input wire logic i_sequential_chain_four,
	input wire logic i_win_64k,
	input wire logic i_write,
	input wire logic [31:0] i_addr,
	input wire logic [7:0] i_aperture,
	output vhpm_pkg::vhpm_pick_t o_pick,
	output logic o_win_hit,
	output vhpm_pkg::vhpm_fbaddr_t o_fb_addr,
	output logic o_ap_hit,
	output vhpm_pkg::vhpm_fbaddr_t o_ap_addr
);
	import vhpm_pkg::*;

	// ----------------------------------------
	// Page arithmetic
	// ----------------------------------------
	// RULE3 page step size
	// Page as 32K or 8K step plus in-window offset
	function automatic vhpm_fbaddr_t page_addr(input vhpm_page_t pg, input logic [14:0] off,
		input logic seq);
		if (seq) begin
			page_addr = {2'h0, pg, off[12:0]};
		end else begin
			page_addr = {pg, off};
		end
	endfunction

	logic legacy_seg;
	logic [14:0] win_off;
	logic in_span;
	vhpm_fbaddr_t low_addr;
	vhpm_fbaddr_t high_addr;

	// ----------------------------------------
	// Window decode
	// ----------------------------------------
	// Host segment A0000h-AFFFFh
	assign legacy_seg = (i_addr[31:16] == `VHPM_LEGACY_SEG);
	assign win_off = i_addr[14:0];
	// RULE4 first window span
	// RULE5 second window span
	// Span is 8K in sequential chain-4, 32K otherwise
	assign in_span = i_sequential_chain_four ? (i_addr[14:13] == 2'h0) : 1'b1;
	// Windows at A0000h and A8000h
	assign o_win_hit = legacy_seg && in_span;

	// RULE15 cycle type pick
	// RULE16 address bit pick
	// Cycle type or host address bit picks the page
	always_comb begin
		if (!i_page_pick_control) begin
			o_pick = i_write ? VHPM_PICK_HIGH : VHPM_PICK_LOW;
		end else if (i_win_64k) begin
			o_pick = i_addr[15] ? VHPM_PICK_HIGH : VHPM_PICK_LOW;
		end else begin
			o_pick = i_addr[16] ? VHPM_PICK_HIGH : VHPM_PICK_LOW;
		end
	end

	// Both candidate addresses, then the pick
	assign low_addr = page_addr(i_page_low, win_off, i_sequential_chain_four);
	assign high_addr = page_addr(i_page_high, win_off, i_sequential_chain_four);
	assign o_fb_addr = (o_pick == VHPM_PICK_HIGH) ? high_addr : low_addr;

	// ----------------------------------------
	// Aperture decode
	// ----------------------------------------
	// RULE13 FFh maps nothing
	// Only the 01 pattern maps; FFh and other codes do not
	assign o_ap_hit = legacy_seg && (i_aperture[7:6] == `VHPM_AP_USE_PAT);
	// RULE11 aperture address forming
	assign o_ap_addr = {i_aperture[5:0], i_addr[15:0]};
endmodule

// ---- design/vhpm_top.sv ----
// Behaviour
// RULE1 - Low window page is seven bits placing the window inside 4 MB.
// RULE2 - High window page is seven bits relocating the other window likewise.
// RULE3 - Pages step 32K normally, 8K in sequential chain-four mode.
// RULE4 - First window starts at A0000h, spanning 8K or 32K.
// RULE5 - Second window starts at A8000h, spanning 8K or 32K.
// RULE6 - Page registers read bit 7 as zero; reset value not guaranteed.
// RULE7 - Enable bit one turns on extended mode and base-located frame access.
// RULE8 - Enable bit zero disables; resets to zero; other bits read zero.
// RULE9 - Three-bit base field matches CPU address bits 26 to 24.
// RULE10 - Base register upper five bits read zero; resets to zero.
// RULE11 - Aperture low six bits over host low sixteen give 22-bit address.
// RULE12 - Software writes aperture top bits as 01 to use it.
// RULE13 - Aperture resets to FFh and then performs no mapping.
// RULE14 - Software only programs FFh or top-bits-01 aperture values.
// RULE15 - Pick control chooses cycle type or address bit for page choice.
// RULE16 - With pick control set, address bit 16 or 15 picks by window size.
// RULE17 - Host writes index port, then accesses data port; device decodes both.
`timescale 1ns/10ps
`include "vhpm_params.svh"
module vhpm_top (
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire logic i_io_wr,
	input wire logic i_io_rd,
	input wire logic i_io_data_sel,
	input wire logic [7:0] i_io_wdata,
	input wire logic i_mem_valid,
	input wire logic i_mem_write,
	input wire logic [31:0] i_mem_addr,
	input wire logic i_page_pick_control,
	input wire logic i_sequential_chain_four,
	input wire logic i_win_64k,
	output logic [7:0] o_io_rdata,
	output logic o_io_rvalid,
	output logic o_ext_enable,
	output logic [2:0] o_ext_base,
	output logic o_ext_hit,
	output logic o_fb_valid,
	output vhpm_pkg::vhpm_fbaddr_t o_fb_addr,
	output logic o_ap_hit,
	output vhpm_pkg::vhpm_fbaddr_t o_ap_addr
);
	import vhpm_pkg::*;

	logic [7:0] index_q;
	vhpm_page_t low_window_page_q;
	vhpm_page_t high_window_page_q;
	logic [2:0] base_q;
	logic [7:0] aperture_q;
	logic data_wr;
	logic [7:0] rdata_d;
	vhpm_pick_t pick;
	logic win_hit;
	vhpm_fbaddr_t fb_addr_d;
	logic ap_hit_d;
	vhpm_fbaddr_t ap_addr_d;

	// ----------------------------------------
	// Register read decode
	// ----------------------------------------
	// Unmapped indices read as zero; reserved bits are zero-filled
	function automatic logic [7:0] reg_read(input logic [7:0] idx, input vhpm_page_t p0,
		input vhpm_page_t p1, input logic en, input logic [2:0] gb, input logic [7:0] ap);
		unique case (idx)
			`VHPM_IDX_LOW_PAGE: reg_read = {1'b0, p0};
			`VHPM_IDX_HIGH_PAGE: reg_read = {1'b0, p1};
			`VHPM_IDX_EXT_ENABLE: reg_read = {en, 7'h00};
			`VHPM_IDX_EXT_BASE: reg_read = {5'h00, gb};
			`VHPM_IDX_APERTURE: reg_read = ap;
			default: reg_read = 8'h00;
		endcase
	endfunction

	// ----------------------------------------
	// Indexed port access
	// ----------------------------------------
	assign data_wr = i_io_wr && i_io_data_sel;

	// RULE17 index port write
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			index_q <= `VHPM_INDEX_RST;
		end else if (i_io_wr && !i_io_data_sel) begin
			index_q <= i_io_wdata;
		end
	end

	// RULE1 low page store
	// Reset to a known value although software must not rely on it
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			low_window_page_q <= `VHPM_PAGE_RST;
		end else if (data_wr && index_q == `VHPM_IDX_LOW_PAGE) begin
			low_window_page_q <= i_io_wdata[6:0];
		end
	end

	// RULE2 high page store
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			high_window_page_q <= `VHPM_PAGE_RST;
		end else if (data_wr && index_q == `VHPM_IDX_HIGH_PAGE) begin
			high_window_page_q <= i_io_wdata[6:0];
		end
	end

	// RULE7 enable bit write
	// RULE8 clears on zero, resets low
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			o_ext_enable <= 1'b0;
		end else if (data_wr && index_q == `VHPM_IDX_EXT_ENABLE) begin
			o_ext_enable <= i_io_wdata[`VHPM_ENABLE_BIT];
		end
	end

	// RULE10 base field store
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			base_q <= `VHPM_BASE_RST;
		end else if (data_wr && index_q == `VHPM_IDX_EXT_BASE) begin
			base_q <= i_io_wdata[2:0];
		end
	end

	// RULE13 aperture resets disabled
	// Any value is stored; only FFh and 01xxxxxx are meaningful to software
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			aperture_q <= `VHPM_APERTURE_RST;
		end else if (data_wr && index_q == `VHPM_IDX_APERTURE) begin
			aperture_q <= i_io_wdata;
		end
	end

	// RULE6 reserved bits read zero
	assign rdata_d = reg_read(index_q, low_window_page_q, high_window_page_q, o_ext_enable,
		base_q, aperture_q);

	// Read data registered; index port itself reads back the index
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			o_io_rdata <= 8'h00;
			o_io_rvalid <= 1'b0;
		end else begin
			o_io_rvalid <= i_io_rd;
			if (i_io_rd) begin
				o_io_rdata <= i_io_data_sel ? rdata_d : index_q;
			end
		end
	end

	assign o_ext_base = base_q;

	// ----------------------------------------
	// Host memory mapping
	// ----------------------------------------
	vhpm_map u_map (
		.i_page_low(low_window_page_q),
		.i_page_high(high_window_page_q),
		.i_page_pick_control(i_page_pick_control),
		.i_sequential_chain_four(i_sequential_chain_four),
		.i_win_64k(i_win_64k),
		.i_write(i_mem_write),
		.i_addr(i_mem_addr),
		.i_aperture(aperture_q),
		.o_pick(pick),
		.o_win_hit(win_hit),
		.o_fb_addr(fb_addr_d),
		.o_ap_hit(ap_hit_d),
		.o_ap_addr(ap_addr_d)
	);

	// RULE4 window translation result
	// RULE5 second window likewise
	// One cycle of latency keeps the outputs on flops
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			o_fb_valid <= 1'b0;
			o_fb_addr <= '0;
			o_ap_hit <= 1'b0;
			o_ap_addr <= '0;
		end else begin
			o_fb_valid <= i_mem_valid && win_hit;
			o_fb_addr <= fb_addr_d;
			// RULE11 aperture address forming
			o_ap_hit <= i_mem_valid && ap_hit_d;
			o_ap_addr <= ap_addr_d;
		end
	end

	// RULE9 base decode on bits 26-24
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			o_ext_hit <= 1'b0;
		end else begin
			o_ext_hit <= i_mem_valid && o_ext_enable && (i_mem_addr[26:24] == base_q);
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);

	sequence s_data_wr(logic [7:0] idx);
		data_wr && index_q == idx;
	endsequence
	sequence s_data_rd(logic [7:0] idx);
		i_io_rd && i_io_data_sel && index_q == idx;
	endsequence
	sequence s_win_cycle;
		i_mem_valid && win_hit;
	endsequence

	enable_set_a: assert property (s_data_wr(`VHPM_IDX_EXT_ENABLE) ##0 i_io_wdata[7] // RULE7
		|=> o_ext_enable ##1 (o_ext_enable || $past(data_wr)))
		else $error("enable bit did not set");
	enable_clear_a: assert property (s_data_wr(`VHPM_IDX_EXT_ENABLE) ##0 !i_io_wdata[7] // RULE8
		|=> !o_ext_enable)
		else $error("enable bit did not clear");
	enable_read_a: assert property (s_data_rd(`VHPM_IDX_EXT_ENABLE) // RULE8
		|=> o_io_rvalid && o_io_rdata[6:0] == 7'h00 && o_io_rdata[7] == o_ext_enable)
		else $error("enable register read wrong");
	page_read_a: assert property ((s_data_rd(`VHPM_IDX_LOW_PAGE) or // RULE6
		s_data_rd(`VHPM_IDX_HIGH_PAGE)) |=> o_io_rdata[7] == 1'b0)
		else $error("page bit 7 not zero");
	base_read_a: assert property (s_data_rd(`VHPM_IDX_EXT_BASE) // RULE10
		|=> o_io_rdata == {5'h00, base_q})
		else $error("base register read wrong");
	base_hit_a: assert property (i_mem_valid && o_ext_enable && !data_wr && // RULE9
		i_mem_addr[26:24] == base_q |=> o_ext_hit)
		else $error("base decode missed");
	reset_values_a: assert property (!$past(i_rst_b) |-> // RULE13
		aperture_q == 8'hFF && !o_ext_enable && base_q == 3'h0)
		else $error("reset values wrong");
	aperture_off_a: assert property (aperture_q == 8'hFF |=> !o_ap_hit) // RULE13
		else $error("aperture mapped while disabled");
	aperture_addr_a: assert property (i_mem_valid && ap_hit_d |=> o_ap_hit && // RULE11
		o_ap_addr == {$past(aperture_q[5:0]), $past(i_mem_addr[15:0])})
		else $error("aperture address wrong");
	low_page_a: assert property (s_win_cycle ##0 pick == VHPM_PICK_LOW && // RULE1
		!i_sequential_chain_four |=> o_fb_addr[21:15] == $past(low_window_page_q))
		else $error("low page not applied");
	high_page_a: assert property (s_win_cycle ##0 pick == VHPM_PICK_HIGH && // RULE2
		!i_sequential_chain_four |=> o_fb_addr[21:15] == $past(high_window_page_q))
		else $error("high page not applied");
	seq_step_a: assert property (s_win_cycle ##0 i_sequential_chain_four && // RULE3
		pick == VHPM_PICK_LOW |=> o_fb_addr[19:13] == $past(low_window_page_q)
		&& o_fb_addr[21:20] == 2'h0)
		else $error("8K step wrong");
	cycle_pick_a: assert property (!i_page_pick_control |-> // RULE15
		pick == (i_mem_write ? VHPM_PICK_HIGH : VHPM_PICK_LOW))
		else $error("cycle type pick wrong");
	addr_pick_a: assert property (i_page_pick_control |-> pick == // RULE16
		((i_win_64k ? i_mem_addr[15] : i_mem_addr[16]) ? VHPM_PICK_HIGH : VHPM_PICK_LOW))
		else $error("address bit pick wrong");
	window_span_a: assert property (i_mem_valid && i_mem_addr[31:16] == 16'h000A && // RULE4
		i_sequential_chain_four && i_mem_addr[14:13] != 2'h0 |=> !o_fb_valid)
		else $error("8K window span exceeded");
endmodule

// ---- tb/vhpm_host.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// Host processor issuing I/O and memory cycles
// ----------------------------------------
module vhpm_host (
	output logic o_io_wr,
	output logic o_io_rd,
	output logic o_io_data_sel,
	output logic [7:0] o_io_wdata,
	output logic o_mem_valid,
	output logic o_mem_write,
	output logic [31:0] o_mem_addr,
	input wire logic i_clk_sys
);
	// Bus idle from time zero
	initial begin
		o_io_wr = 1'b0;
		o_io_rd = 1'b0;
		o_io_data_sel = 1'b0;
		o_io_wdata = 8'h00;
		o_mem_valid = 1'b0;
		o_mem_write = 1'b0;
		o_mem_addr = 32'h0000_0000;
	end
	// index then data
	// One-cycle strobe; released data is inverted so a stale value never matches
	task automatic io(input logic wr, input logic sel, input logic [7:0] d);
		@(negedge i_clk_sys);
		o_io_wr = wr;
		o_io_rd = ~wr;
		o_io_data_sel = sel;
		o_io_wdata = d;
		@(negedge i_clk_sys);
		o_io_wr = 1'b0;
		o_io_rd = 1'b0;
		o_io_wdata = ~d;
	endtask
	// One memory cycle, address inverted once released
	task automatic mem(input logic w, input logic [31:0] a);
		@(negedge i_clk_sys);
		o_mem_valid = 1'b1;
		o_mem_write = w;
		o_mem_addr = a;
		@(negedge i_clk_sys);
		o_mem_valid = 1'b0;
		o_mem_write = ~w;
		o_mem_addr = ~a;
	endtask
endmodule

// ---- tb/vhpm_host_page_mapping_tb_top.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// Bench with register and translation model
// ----------------------------------------
module vga_host_page_mapping_tb_top;
	import vhpm_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic pick = 1'b0, sc = 1'b0, w64 = 1'b0;
	logic io_wr, io_rd, sel, mem_valid, mem_write, rvalid, ext_en, ext_hit, fb_valid, ap_hit;
	logic [7:0] wdata, rdata, m_lo, m_hi, m_en, m_base, m_ap;
	logic [31:0] mem_addr;
	logic [2:0] ext_base;
	vhpm_fbaddr_t fb_addr, ap_addr;
	int mismatches = 0, n_compared = 0, cyc = 0;

	// Clock at 4 ns period
	always #2 clk = ~clk;

	vhpm_host u_host (.o_io_wr(io_wr), .o_io_rd(io_rd), .o_io_data_sel(sel),
		.o_io_wdata(wdata), .o_mem_valid(mem_valid), .o_mem_write(mem_write),
		.o_mem_addr(mem_addr), .i_clk_sys(clk));
	vhpm_top u_dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_io_wr(io_wr), .i_io_rd(io_rd),
		.i_io_data_sel(sel), .i_io_wdata(wdata), .i_mem_valid(mem_valid),
		.i_mem_write(mem_write), .i_mem_addr(mem_addr), .i_page_pick_control(pick),
		.i_sequential_chain_four(sc), .i_win_64k(w64), .o_io_rdata(rdata),
		.o_io_rvalid(rvalid), .o_ext_enable(ext_en), .o_ext_base(ext_base),
		.o_ext_hit(ext_hit), .o_fb_valid(fb_valid), .o_fb_addr(fb_addr),
		.o_ap_hit(ap_hit), .o_ap_addr(ap_addr));

	task automatic give_verdict;
		if (mismatches == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Hang guard, well above the roughly 1500 cycles needed
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			give_verdict();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			mismatches++;
		end
	endtask

	// Model readback; unmapped indices read zero
	function automatic logic [7:0] exp_rd(input logic [7:0] idx);
		case (idx)
			8'h1D: return m_lo;
			8'h1E: return m_hi;
			8'h1F: return m_en;
			8'h20: return m_base;
			8'h21: return m_ap;
			default: return 8'h00;
		endcase
	endfunction

	task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
		u_host.io(1'b1, 1'b0, idx);
		u_host.io(1'b1, 1'b1, d);
		case (idx)
			8'h1D: m_lo = d & 8'h7F;
			8'h1E: m_hi = d & 8'h7F;
			8'h1F: m_en = d & 8'h80;
			8'h20: m_base = d & 8'h07;
			8'h21: m_ap = d;
			default: ;
		endcase
	endtask

	task automatic rd_reg(input logic [7:0] idx);
		u_host.io(1'b1, 1'b0, idx);
		u_host.io(1'b0, 1'b1, 8'h00);
		chk("rvalid", 32'h1, {31'h0, rvalid});
		chk("rdata", {24'h0, exp_rd(idx)}, {24'h0, rdata});
		u_host.io(1'b0, 1'b0, 8'h00);
		chk("index", {24'h0, idx}, {24'h0, rdata});
	endtask

	// One memory cycle against the translation model
	task automatic mem_chk(input logic w, input logic [31:0] a);
		logic seg, hs, win, aph;
		logic [7:0] pg;
		logic [21:0] efb;
		seg = (a[31:16] == 16'h000A);
		hs = pick ? (w64 ? a[15] : a[16]) : w;
		pg = hs ? m_hi : m_lo;
		efb = sc ? {2'h0, pg[6:0], a[12:0]} : {pg[6:0], a[14:0]};
		win = seg && (!sc || a[14:13] == 2'b00);
		aph = seg && m_ap[7:6] == 2'b01;
		u_host.mem(w, a);
		chk("fb_valid", {31'h0, win}, {31'h0, fb_valid});
		if (win) chk("fb_addr", {10'h0, efb}, {10'h0, fb_addr});
		chk("ap_hit", {31'h0, aph}, {31'h0, ap_hit});
		if (aph) chk("ap_addr", {10'h0, m_ap[5:0], a[15:0]}, {10'h0, ap_addr});
		chk("ext_hit", {31'h0, m_en[7] && a[26:24] == m_base[2:0]}, {31'h0, ext_hit});
		chk("ext_enable", {31'h0, m_en[7]}, {31'h0, ext_en});
		chk("ext_base", {29'h0, m_base[2:0]}, {29'h0, ext_base});
	endtask

	// Main sequence
	initial begin
		int k;
		logic [31:0] a;
		m_lo = 8'h00;
		m_hi = 8'h00;
		m_en = 8'h00;
		m_base = 8'h00;
		m_ap = 8'hFF;
		void'($urandom(32'hdead));
		repeat (20) @(negedge clk);
		rst_b = 1'b1;
		for (k = 8'h1D; k <= 8'h22; k++) rd_reg(8'(k));
		mem_chk(1'b0, 32'h000A_1234);
		for (k = 8'h1D; k <= 8'h22; k++) begin
			wr_reg(8'(k), 8'hFF);
			rd_reg(8'(k));
		end
		// Random modes, pages and host cycles
		for (k = 0; k < 256; k++) begin
			if (k % 8 == 0) begin
				{pick, sc, w64} = 3'($urandom);
				wr_reg(8'h1D, 8'($urandom));
				wr_reg(8'h1E, 8'($urandom));
				wr_reg(8'h1F, 8'($urandom));
				wr_reg(8'h20, 8'($urandom));
				wr_reg(8'h21, (k % 16 == 0) ? 8'hFF : {2'b01, 6'($urandom)});
				rd_reg(8'h1D + 8'((k / 8) % 5));
			end
			a = $urandom;
			if (k % 2 == 0) a[31:16] = 16'h000A;
			if (k % 3 == 0) a[26:24] = m_base[2:0];
			mem_chk(1'($urandom), a);
		end
		wr_reg(8'h1F, 8'h80);
		mem_chk(1'b1, {5'h00, m_base[2:0], 24'h0A_0000});
		wr_reg(8'h1F, 8'h00);
		mem_chk(1'b1, {5'h00, m_base[2:0], 24'h0A_0000});
		give_verdict();
	end
endmodule
